// ==== src/ipb_cfg.svh ====
// constants for the interrupt priority bank: offsets, field positions, reset values
// assumes inclusion by the design modules and the test bench; 32-bit apb, word aligned
//
// Contract
// [R1] field code 111 means priority level 7, the highest level
// [R2] field code 001 means level 1; binary value equals the level
// [R3] field code 000 disables the source; it never requests service
// [R4] unimplemented bits always read zero and hold no state
// [R5] every implemented priority bit is readable and writable, reads last written
// [R6] every implemented field resets to 100, priority level 4
// [R7] first register: change 14-12, comparator 10-8, i2c master 6-4, i2c slave 2-0
// [R8] second register: capture 8 at 14-12, capture 7 at 10-8, ext irq1 2-0
// [R9] third register: timer 4 at 14-12, compare 4 at 10-8, compare 3 6-4
// [R10] fourth register: uart tx 14-12, uart rx 10-8, ext irq2 6-4, timer5 2-0
// [R11] fifth register: bits 15-7 unused, spi event 6-4, spi fault 2-0
// [R12] sixth register: capture 5 at 14-12, capture 4 10-8, capture 3 6-4
// [R13] fields drive arbitration continuously; writes take effect next clock edge
`ifndef IPB_CFG_SVH
`define IPB_CFG_SVH
`define IPB_OFS_CHG_CMP_I2C 12'h000
`define IPB_OFS_CAP78_EXT1 12'h004
`define IPB_OFS_TMR4_CMP34 12'h008
`define IPB_OFS_SER2_EXT2_TMR5 12'h00C
`define IPB_OFS_SPI2 12'h010
`define IPB_OFS_CAP345 12'h014
`define IPB_FLD_HI 12
`define IPB_FLD_MH 8
`define IPB_FLD_ML 4
`define IPB_FLD_LO 0
`define IPB_PRIO_RESET 3'h4
`define IPB_MASK_FULL 16'h7777
`define IPB_MASK_NO_ML 16'h7707
`define IPB_MASK_NO_LO 16'h7770
`define IPB_MASK_LOW2 16'h0077
`define IPB_PRIO_MAX 3'h7
`define IPB_PRIO_OFF 3'h0
`endif

// ==== src/ipb_pkg.sv ====
// types for the interrupt priority bank
// assumes the cfg header supplies the numbers
package ipb_pkg;
   typedef logic [2:0] ipb_prio_t;
   typedef struct packed {
      ipb_prio_t inputChange;
      ipb_prio_t comparator;
      ipb_prio_t i2cFirstMaster;
      ipb_prio_t i2cFirstSlave;
      ipb_prio_t captureCh8;
      ipb_prio_t captureCh7;
      ipb_prio_t externalIrq1;
      ipb_prio_t timerFour;
      ipb_prio_t compareCh4;
      ipb_prio_t compareCh3;
      ipb_prio_t serialSecondTx;
      ipb_prio_t serialSecondRx;
      ipb_prio_t externalIrq2;
      ipb_prio_t timerFive;
      ipb_prio_t spiSecondEvent;
      ipb_prio_t spiSecondFault;
      ipb_prio_t captureCh5;
      ipb_prio_t captureCh4;
      ipb_prio_t captureCh3;
   } ipb_prio_bank_t;
   typedef struct packed {
      logic [1:0] level;
      logic enabled;
   } ipb_unused_t;
endpackage

// ==== src/ipb_prio_reg.sv ====
// one 16-bit priority register of four 3-bit fields with a mask of implemented fields
// assumes a one-cycle write strobe from the apb decoder on the same clock
`timescale 1ns/10ps
`include "ipb_cfg.svh"
module ipb_prio_reg #(
   parameter logic [15:0] MASK = `IPB_MASK_FULL
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [15:0] wrData,
   output logic [15:0] value
);
   logic [15:0] value_reg;
   localparam logic [15:0] RESET_VAL = {1'b0, `IPB_PRIO_RESET, 1'b0, `IPB_PRIO_RESET,
      1'b0, `IPB_PRIO_RESET, 1'b0, `IPB_PRIO_RESET} & MASK;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         value_reg <= RESET_VAL; // R6
      else if (wrEn)
         value_reg <= wrData & MASK; // R4 R5 R13
   end
   assign value = value_reg & MASK; // R4
endmodule

// ==== src/ipb_bank.sv ====
// interrupt priority bank: six priority registers on an apb slave
// assumes apb master on clk; fields feed arbitration logic outside this block
`timescale 1ns/10ps
`include "ipb_cfg.svh"
module ipb_bank (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output ipb_pkg::ipb_prio_bank_t prio,
   output logic [18:0] srcEnabled
);
   logic [5:0] sel;
   logic [5:0] wrEn;
   logic [15:0] wrData [6];
   logic [15:0] regVal [6];
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic unmapped;
   logic access;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic prioOn(input ipb_pkg::ipb_prio_t p);
      prioOn = (p != `IPB_PRIO_OFF); // R3
   endfunction

   assign access = psel && penable;
   always_comb
   begin
      sel = 6'h00;
      if (paddr == `IPB_OFS_CHG_CMP_I2C)
         sel = 6'h01;
      else if (paddr == `IPB_OFS_CAP78_EXT1)
         sel = 6'h02;
      else if (paddr == `IPB_OFS_TMR4_CMP34)
         sel = 6'h04;
      else if (paddr == `IPB_OFS_SER2_EXT2_TMR5)
         sel = 6'h08;
      else if (paddr == `IPB_OFS_SPI2)
         sel = 6'h10;
      else if (paddr == `IPB_OFS_CAP345)
         sel = 6'h20;
   end
   assign unmapped = (sel == 6'h00);

   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : gReg
         localparam logic [15:0] M = (g == 1) ? `IPB_MASK_NO_ML :
                                     (g == 2 || g == 5) ? `IPB_MASK_NO_LO :
                                     (g == 4) ? `IPB_MASK_LOW2 : `IPB_MASK_FULL;
         assign wrEn[g] = access && pwrite && sel[g];
         assign wrData[g] = merge(regVal[g], pwdata, pstrb);
         ipb_prio_reg #(.MASK(M)) uReg (
            .clk(clk),
            .rst(rst),
            .wrEn(wrEn[g]),
            .wrData(wrData[g]),
            .value(regVal[g])
         );
      end
   endgenerate

   always_comb
   begin
      prdata_next = 32'h0000_0000;
      for (int i = 0; i < 6; i++)
      begin
         if (sel[i])
            prdata_next = {16'h0000, regVal[i]}; // R4 R5
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prdata_reg <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata_reg <= prdata_next;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pslverr_reg <= 1'b0;
      else if (psel && !penable)
         pslverr_reg <= unmapped;
   end

   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = access && pslverr_reg;

   // R7
   assign prio.inputChange = regVal[0][`IPB_FLD_HI +: 3];
   assign prio.comparator = regVal[0][`IPB_FLD_MH +: 3];
   assign prio.i2cFirstMaster = regVal[0][`IPB_FLD_ML +: 3];
   assign prio.i2cFirstSlave = regVal[0][`IPB_FLD_LO +: 3];
   // R8
   assign prio.captureCh8 = regVal[1][`IPB_FLD_HI +: 3];
   assign prio.captureCh7 = regVal[1][`IPB_FLD_MH +: 3];
   assign prio.externalIrq1 = regVal[1][`IPB_FLD_LO +: 3];
   // R9
   assign prio.timerFour = regVal[2][`IPB_FLD_HI +: 3];
   assign prio.compareCh4 = regVal[2][`IPB_FLD_MH +: 3];
   assign prio.compareCh3 = regVal[2][`IPB_FLD_ML +: 3];
   // R10
   assign prio.serialSecondTx = regVal[3][`IPB_FLD_HI +: 3];
   assign prio.serialSecondRx = regVal[3][`IPB_FLD_MH +: 3];
   assign prio.externalIrq2 = regVal[3][`IPB_FLD_ML +: 3];
   assign prio.timerFive = regVal[3][`IPB_FLD_LO +: 3];
   // R11
   assign prio.spiSecondEvent = regVal[4][`IPB_FLD_ML +: 3];
   assign prio.spiSecondFault = regVal[4][`IPB_FLD_LO +: 3];
   // R12
   assign prio.captureCh5 = regVal[5][`IPB_FLD_HI +: 3];
   assign prio.captureCh4 = regVal[5][`IPB_FLD_MH +: 3];
   assign prio.captureCh3 = regVal[5][`IPB_FLD_ML +: 3];

   // priority values pass straight through: level equals code, 1 lowest, 7 highest
   always_comb
   begin
      for (int k = 0; k < 19; k++)
         srcEnabled[k] = prioOn(prio[k*3 +: 3]); // R1 R2 R3 R13
   end

   property p_resetLevel;
      @(posedge clk) $fell(rst) |-> (prio == {19{`IPB_PRIO_RESET}});
   endproperty
   a_resetLevel: assert property (p_resetLevel) else $error("field not at level 4 after reset"); // R6

   property p_unusedZero;
      @(posedge clk) disable iff (rst) (regVal[4][15:7] == 9'h000) && (regVal[1][7:3] == 5'h00);
   endproperty
   a_unusedZero: assert property (p_unusedZero) else $error("unimplemented bits not zero"); // R4

   property p_writeTakes;
      @(posedge clk) disable iff (rst)
      (access && pwrite && sel[0] && pstrb[1:0] == 2'b11) |=> (regVal[0] == ($past(pwdata[15:0]) & `IPB_MASK_FULL));
   endproperty
   a_writeTakes: assert property (p_writeTakes) else $error("write not taken next edge"); // R5

   property p_hold;
      @(posedge clk) disable iff (rst) !wrEn[3] |=> $stable(regVal[3]);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without write"); // R13

   property p_disable;
      @(posedge clk) disable iff (rst) (prio.timerFive == `IPB_PRIO_OFF) |-> !srcEnabled[5];
   endproperty
   a_disable: assert property (p_disable) else $error("disabled source enabled"); // R3

   property p_maxLevel;
      @(posedge clk) disable iff (rst) (prio.inputChange == `IPB_PRIO_MAX) |-> srcEnabled[18];
   endproperty
   a_maxLevel: assert property (p_maxLevel) else $error("level 7 not enabled"); // R1

   property p_lowLevel;
      @(posedge clk) disable iff (rst) (prio.captureCh3 == 3'h1) |-> srcEnabled[0];
   endproperty
   a_lowLevel: assert property (p_lowLevel) else $error("level 1 not enabled"); // R2

   property p_field;
      @(posedge clk) disable iff (rst) prio.spiSecondEvent == regVal[4][6:4];
   endproperty
   a_field: assert property (p_field) else $error("spi event field misplaced"); // R11
endmodule

// ==== verif/ipb_bank_test.sv ====
// self-checking bench for the interrupt priority bank, driven over apb
// assumes the cfg header offsets and masks, zero-wait apb slave, prio struct order of the package
`timescale 1ns/10ps
`include "ipb_cfg.svh"
module ipb_bank_test;
   localparam logic [15:0] MASKS [6] = '{`IPB_MASK_FULL, `IPB_MASK_NO_ML, `IPB_MASK_NO_LO,
      `IPB_MASK_FULL, `IPB_MASK_LOW2, `IPB_MASK_NO_LO};
   localparam logic [11:0] OFS [6] = '{`IPB_OFS_CHG_CMP_I2C, `IPB_OFS_CAP78_EXT1, `IPB_OFS_TMR4_CMP34,
      `IPB_OFS_SER2_EXT2_TMR5, `IPB_OFS_SPI2, `IPB_OFS_CAP345};
   localparam logic [15:0] VALS [5] = '{16'hFFFF, 16'h0000, 16'h1111, 16'h5A3C, 16'h6E58};
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic err;
   ipb_pkg::ipb_prio_bank_t prio;
   logic [18:0] srcEnabled;
   logic [15:0] mdl [6];
   int nMismatch = 0;
   int checks = 0;
   int cyc = 0;

   ipb_bank i_ipb_bank (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .prio(prio), .srcEnabled(srcEnabled));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         nMismatch++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; answer taken at the edge where pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rdat, output logic rerr);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [56:0] expPrio();
      return {mdl[0][14:12], mdl[0][10:8], mdl[0][6:4], mdl[0][2:0], mdl[1][14:12], mdl[1][10:8],
         mdl[1][2:0], mdl[2][14:12], mdl[2][10:8], mdl[2][6:4], mdl[3][14:12], mdl[3][10:8],
         mdl[3][6:4], mdl[3][2:0], mdl[4][6:4], mdl[4][2:0], mdl[5][14:12], mdl[5][10:8], mdl[5][6:4]};
   endfunction

   task automatic wr(input int idx, input logic [15:0] d, input logic [3:0] s);
      logic [15:0] be;
      apb(1'b1, OFS[idx], {16'h0000, d}, s, rd, err);
      be = {{8{s[1]}}, {8{s[0]}}};
      mdl[idx] = ((mdl[idx] & ~be) | (d & be)) & MASKS[idx];
      @(negedge clk);
      chk(prio, expPrio());
   endtask

   task automatic checkAll();
      logic [56:0] p;
      logic [18:0] e;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, OFS[i], 32'h0000_0000, 4'h0, rd, err);
         chk(rd, {16'h0000, mdl[i]});
         chk(err, 1'b0);
      end
      p = expPrio();
      for (int j = 0; j < 19; j++)
         e[j] = |p[3*j+:3];
      chk(prio, p);
      chk(srcEnabled, e);
   endtask

   task automatic resetModel();
      for (int i = 0; i < 6; i++)
         mdl[i] = {4{1'b0, `IPB_PRIO_RESET}} & MASKS[i];
   endtask

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      resetModel();
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      checkAll();
      $display("test reset defaults done");
      for (int k = 0; k < 5; k++)
      begin
         for (int i = 0; i < 6; i++)
            wr(i, VALS[k], 4'h3);
         checkAll();
      end
      $display("test field codes done");
      for (int i = 0; i < 6; i++)
         wr(i, 16'h7007, 4'h2);
      checkAll();
      $display("test byte lanes done");
      apb(1'b1, 12'h018, 32'h0000_FFFF, 4'hF, rd, err);
      chk(err, 1'b1);
      apb(1'b0, 12'h018, 32'h0000_0000, 4'h0, rd, err);
      chk(rd, 32'h0000_0000);
      chk(err, 1'b1);
      checkAll();
      $display("test unmapped address done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      chk(prio, {19{`IPB_PRIO_RESET}});
      rst <= 1'b0;
      resetModel();
      checkAll();
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
